// file: rtl/pfc_pkg.sv
package pfc_pkg;
  // clock and pin timing
  localparam int CLK_NS   = 10;
  localparam int T_WP_NS  = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 100;
  localparam int T_RP_NS  = 500;
  localparam int T_RH_NS  = 50;
  localparam int WP_CYC   = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WPH_CYC  = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_CYC   = (T_RP_NS + CLK_NS - 1) / CLK_NS;
  localparam int RH_CYC   = (T_RH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CW       = 8;

  // flash bus; address bit 0 is the sub-word select of narrow mode
  localparam int AW       = 26;
  localparam int DW       = 64;
  localparam int SECT_LSB = 17;
  localparam int DQ_TOG   = 6;

  // command cycles
  localparam logic [7:0]    CMD_UNLK1  = 8'hAA;
  localparam logic [7:0]    CMD_UNLK2  = 8'h55;
  localparam logic [7:0]    CMD_PROG   = 8'hA0;
  localparam logic [7:0]    CMD_ERASE  = 8'h80;
  localparam logic [7:0]    CMD_SECT   = 8'h30;
  localparam logic [7:0]    CMD_BYPASS = 8'h20;
  localparam logic [7:0]    CMD_BYPX1  = 8'h90;
  localparam logic [7:0]    CMD_BYPX2  = 8'h00;
  localparam logic [7:0]    CMD_SUSP   = 8'hB0;
  localparam logic [7:0]    CMD_RES    = 8'h30;
  localparam logic [AW-1:0] ADR_UNLK1  = 26'h0000AAA;
  localparam logic [AW-1:0] ADR_UNLK2  = 26'h0000554;

  // register map
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_ADDR  = 8'h04;
  localparam logic [7:0] OFS_WDLO  = 8'h08;
  localparam logic [7:0] OFS_WDHI  = 8'h0C;
  localparam logic [7:0] OFS_RDLO  = 8'h10;
  localparam logic [7:0] OFS_RDHI  = 8'h14;
  localparam logic [7:0] OFS_STAT  = 8'h18;
  localparam logic [7:0] OFS_CFG   = 8'h1C;
  localparam int CTRL_START = 0;
  localparam int CTRL_OPLSB = 1;
  localparam int CTRL_HWRST = 4;
  localparam int CFG_WP     = 0;
  localparam int CFG_WIDE   = 1;
  localparam logic [1:0] CFG_RST = 2'h3;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR  = 2;
  localparam int ST_BYP  = 3;
  localparam int ST_SUSP = 4;
  localparam int ST_RDY  = 5;

  typedef enum logic [2:0] {
    OP_READ, OP_PROG, OP_ERASE, OP_BYP_ENTER,
    OP_BYP_PROG, OP_BYP_EXIT, OP_SUSPEND, OP_RESUME
  } pfc_op_t;
endpackage

// file: rtl/pfc_bus_cycle.sv
module pfc_bus_cycle (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // request
  input  wire logic                 req,
  input  wire logic                 wr,
  input  wire logic [pfc_pkg::AW-1:0] addr,
  input  wire logic [pfc_pkg::DW-1:0] wdata,
  output logic                      ack,
  output logic [pfc_pkg::DW-1:0]    rdata,
  // flash pins
  output logic                      cs_n,
  output logic                      we_n,
  output logic                      oe_n,
  output logic [pfc_pkg::AW-1:0]    f_addr,
  output logic [pfc_pkg::DW-1:0]    dq_o,
  output logic                      dq_oe,
  input  wire logic [pfc_pkg::DW-1:0] dq_i
);
  import pfc_pkg::*;
  typedef enum logic [1:0] {B_IDLE, B_SET, B_STROBE, B_HOLD} pfc_bst_t;
  pfc_bst_t       st_r;
  logic [CW-1:0]  cnt_r;
  logic           wr_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r   <= B_IDLE;
      cnt_r  <= '0;
      wr_r   <= 1'b0;
      ack    <= 1'b0;
      cs_n   <= 1'b1;
      we_n   <= 1'b1;
      oe_n   <= 1'b1;
      f_addr <= '0;
      dq_o   <= '0;
      dq_oe  <= 1'b0;
      rdata  <= '0;
    end else begin
      ack <= 1'b0;
      case (st_r)
        B_IDLE: if (req) begin
          // address and data settle one cycle before the strobe
          f_addr <= addr;
          dq_o   <= wdata;
          dq_oe  <= wr;
          wr_r   <= wr;
          cs_n   <= 1'b0;
          st_r   <= B_SET;
        end
        B_SET: begin
          we_n  <= ~wr_r;
          oe_n  <= wr_r;
          cnt_r <= wr_r ? CW'(WP_CYC - 1) : CW'(ACC_CYC - 1);
          st_r  <= B_STROBE;
        end
        B_STROBE: if (cnt_r == '0) begin
          // rising write strobe latches address and data in the device
          we_n  <= 1'b1;
          oe_n  <= 1'b1;
          if (!wr_r) rdata <= dq_i;
          cnt_r <= CW'(WPH_CYC - 1);
          st_r  <= B_HOLD;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
        B_HOLD: if (cnt_r == '0) begin
          cs_n  <= 1'b1;
          dq_oe <= 1'b0;
          ack   <= 1'b1;
          st_r  <= B_IDLE;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
        default: st_r <= B_IDLE;
      endcase
    end
  end
endmodule

// file: rtl/pfc_rst_pulse.sv
module pfc_rst_pulse (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // control
  input  wire logic go,
  output logic      done,
  // pin
  output logic      reset_pin_n
);
  import pfc_pkg::*;
  logic [CW-1:0] cnt_r;
  logic          rec_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= '0;
      rec_r       <= 1'b0;
      done        <= 1'b0;
      reset_pin_n <= 1'b1;
    end else begin
      done <= 1'b0;
      if (go) begin
        reset_pin_n <= 1'b0;
        rec_r       <= 1'b0;
        cnt_r       <= CW'(RP_CYC - 1);
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end else if (!reset_pin_n) begin
        // recovery time before the first access after release
        reset_pin_n <= 1'b1;
        rec_r       <= 1'b1;
        cnt_r       <= CW'(RH_CYC - 1);
      end else if (rec_r) begin
        rec_r <= 1'b0;
        done  <= 1'b1;
      end
    end
  end
endmodule

// file: rtl/pfc_flash_host.sv
// Notes on behaviour
// - outside bypass mode, program and erase start only by a full command write sequence
// - bypass mode programs in two writes, otherwise four writes
// - erase suspend allows reads and programs of other sectors; resume finishes
// - program suspend allows reads of other sectors only; resume finishes
//
// Local design decisions: the APB interface to the registers and the register offsets.
module pfc_flash_host (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // apb slave
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // flash pins
  output logic                        flash_cs_n,
  output logic                        flash_we_n,
  output logic                        flash_oe_n,
  output logic [pfc_pkg::AW-1:0]      flash_addr,
  output logic [pfc_pkg::DW-1:0]      flash_dq_o,
  output logic                        flash_dq_oe,
  input  wire logic [pfc_pkg::DW-1:0] flash_dq_i,
  output logic                        flash_reset_n,
  output logic                        flash_wp_n,
  output logic                        flash_byte_n,
  input  wire logic                   ready_busy_n
);
  import pfc_pkg::*;
  typedef enum logic [2:0] {
    S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_PWAIT, S_RESET
  } pfc_st_t;

  pfc_st_t          st_r;
  pfc_op_t          op_r, cmd_op_r, req_op;
  logic [AW-1:0]    reg_addr_r, op_addr_r;
  logic [DW-1:0]    wdata_r, rdata_r;
  logic [2:0]       idx_r;
  logic             pend_r, hw_go_r, done_r, err_r, byp_r, susp_r;
  logic             susp_erase_r, tog_r, first_r;
  logic [AW-1-SECT_LSB:0] susp_sect_r;
  logic [1:0]       cfg_r;
  logic             wr_acc, rd_acc, hit;
  logic             take, legal, susp_take;
  logic             b_ack, b_req, b_wr, rst_done;
  logic [DW-1:0]    b_rdata;
  logic             s_last;
  logic [AW-1:0]    s_addr;
  logic [DW-1:0]    s_data;
  logic             needs_poll, stat_ok;

  assign wr_acc = psel & penable & pready & pwrite;
  assign rd_acc = psel & penable & ~pready & ~pwrite;
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_ADDR) ||
               (paddr == OFS_WDLO) || (paddr == OFS_WDHI) ||
               (paddr == OFS_RDLO) || (paddr == OFS_RDHI) ||
               (paddr == OFS_STAT) || (paddr == OFS_CFG);
  assign req_op = pfc_op_t'(pwdata[CTRL_OPLSB +: 3]);

  // apb answer: one wait state, then pready for a single cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= '0;
      if (rd_acc) begin
        if (paddr == OFS_ADDR) prdata <= 32'(reg_addr_r);
        else if (paddr == OFS_WDLO) prdata <= wdata_r[31:0];
        else if (paddr == OFS_WDHI) prdata <= wdata_r[63:32];
        else if (paddr == OFS_RDLO) prdata <= rdata_r[31:0];
        else if (paddr == OFS_RDHI) prdata <= rdata_r[63:32];
        else if (paddr == OFS_CFG) prdata <= 32'(cfg_r);
        else if (paddr == OFS_STAT) begin
          prdata[ST_BUSY] <= (st_r != S_IDLE);
          prdata[ST_DONE] <= done_r;
          prdata[ST_ERR]  <= err_r;
          prdata[ST_BYP]  <= byp_r;
          prdata[ST_SUSP] <= susp_r;
          prdata[ST_RDY]  <= ready_busy_n;
        end
      end
    end
  end

  // software registers; width and write-protect levels go straight out
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr_r <= '0;
      wdata_r    <= '0;
      cfg_r      <= CFG_RST;
    end else if (wr_acc) begin
      if (paddr == OFS_ADDR) reg_addr_r <= pwdata[AW-1:0];
      else if (paddr == OFS_WDLO) wdata_r[31:0] <= pwdata;
      else if (paddr == OFS_WDHI) wdata_r[63:32] <= pwdata;
      else if (paddr == OFS_CFG) cfg_r <= pwdata[1:0];
    end
  end
  assign flash_wp_n   = cfg_r[CFG_WP];
  assign flash_byte_n = cfg_r[CFG_WIDE];

  // start request stays pending until the sequencer takes it or a hardware reset drops it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pend_r   <= 1'b0;
      hw_go_r  <= 1'b0;
      cmd_op_r <= OP_READ;
    end else begin
      hw_go_r <= wr_acc && (paddr == OFS_CTRL) && pwdata[CTRL_HWRST];
      if (wr_acc && (paddr == OFS_CTRL) && pwdata[CTRL_START] &&
          !pwdata[CTRL_HWRST]) begin
        pend_r   <= 1'b1;
        cmd_op_r <= req_op;
      end else if (take || hw_go_r) begin
        pend_r <= 1'b0;
      end
    end
  end

  // which orders the device will accept in its present mode
  always_comb begin
    legal = 1'b0;
    case (cmd_op_r)
      OP_READ:      legal = !susp_r ||
                      (reg_addr_r[AW-1:SECT_LSB] != susp_sect_r);
      OP_PROG:      legal = !byp_r && (!susp_r || (susp_erase_r &&
                      reg_addr_r[AW-1:SECT_LSB] != susp_sect_r));
      OP_ERASE:     legal = !byp_r && !susp_r;
      OP_BYP_ENTER: legal = !byp_r && !susp_r;
      OP_BYP_PROG:  legal = byp_r && !susp_r;
      OP_BYP_EXIT:  legal = byp_r && !susp_r;
      OP_SUSPEND:   legal = (st_r == S_POLL) && !susp_r &&
                      (op_r == OP_PROG || op_r == OP_ERASE);
      OP_RESUME:    legal = susp_r;
      default:      legal = 1'b0;
    endcase
  end
  assign susp_take = pend_r && (st_r == S_POLL) && (cmd_op_r == OP_SUSPEND);
  assign take = pend_r && !hw_go_r && ((st_r == S_IDLE) || susp_take);
  assign needs_poll = (op_r != OP_READ) && (op_r != OP_BYP_ENTER) &&
                      (op_r != OP_BYP_EXIT);

  // command sequences, one bus write per step
  always_comb begin
    s_last = 1'b1;
    s_addr = op_addr_r;
    s_data = {{(DW-8){1'b0}}, CMD_SUSP};
    case (op_r)
      OP_PROG, OP_ERASE, OP_BYP_ENTER: begin
        s_last = 1'b0;
        case (idx_r)
          3'h0: begin s_addr = ADR_UNLK1; s_data[7:0] = CMD_UNLK1; end
          3'h1: begin s_addr = ADR_UNLK2; s_data[7:0] = CMD_UNLK2; end
          3'h2: begin
            s_addr = ADR_UNLK1;
            s_data[7:0] = (op_r == OP_PROG) ? CMD_PROG :
                          (op_r == OP_ERASE) ? CMD_ERASE : CMD_BYPASS;
            s_last = (op_r == OP_BYP_ENTER);
          end
          3'h3: begin
            if (op_r == OP_PROG) begin
              s_data = wdata_r;
              s_last = 1'b1;
            end else begin
              s_addr = ADR_UNLK1;
              s_data[7:0] = CMD_UNLK1;
            end
          end
          3'h4: begin s_addr = ADR_UNLK2; s_data[7:0] = CMD_UNLK2; end
          default: begin s_data[7:0] = CMD_SECT; s_last = 1'b1; end
        endcase
      end
      OP_BYP_PROG: begin
        s_last = (idx_r != 3'h0);
        if (idx_r == 3'h0) s_data[7:0] = CMD_PROG;
        else s_data = wdata_r;
      end
      OP_BYP_EXIT: begin
        s_last = (idx_r != 3'h0);
        s_data[7:0] = (idx_r == 3'h0) ? CMD_BYPX1 : CMD_BYPX2;
      end
      OP_RESUME: s_data[7:0] = CMD_RES;
      default: s_data[7:0] = CMD_SUSP;
    endcase
  end

  assign b_req = (st_r == S_ISSUE) || ((st_r == S_POLL) && !susp_take);
  assign b_wr  = (st_r == S_ISSUE) && (op_r != OP_READ);
  assign stat_ok = !first_r && (b_rdata[DQ_TOG] == tog_r) && ready_busy_n;

  // main sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r      <= S_IDLE;
      op_r      <= OP_READ;
      op_addr_r <= '0;
      idx_r     <= '0;
      tog_r     <= 1'b0;
      first_r   <= 1'b1;
      rdata_r   <= '0;
    end else if (hw_go_r) begin
      st_r <= S_RESET;
    end else begin
      case (st_r)
        S_IDLE, S_POLL: if (take && legal) begin
          op_r  <= cmd_op_r;
          idx_r <= '0;
          st_r  <= S_ISSUE;
          if (cmd_op_r == OP_RESUME)
            op_addr_r <= {susp_sect_r, {SECT_LSB{1'b0}}};
          else if (cmd_op_r != OP_SUSPEND)
            op_addr_r <= reg_addr_r;
        end else if (st_r == S_POLL && !take) begin
          // no suspend taken: a status read went out, so wait for its answer
          st_r <= S_PWAIT;
        end
        S_ISSUE: st_r <= S_WAIT;
        S_WAIT: if (b_ack) begin
          if (op_r == OP_READ) begin
            rdata_r <= b_rdata;
            st_r    <= S_IDLE;
          end else if (!s_last) begin
            idx_r <= idx_r + 1'b1;
            st_r  <= S_ISSUE;
          end else begin
            first_r <= 1'b1;
            st_r    <= needs_poll ? S_POLL : S_IDLE;
          end
        end
        S_PWAIT: if (b_ack) begin
          // toggle bit steady and pin ready: operation over
          tog_r   <= b_rdata[DQ_TOG];
          first_r <= 1'b0;
          st_r    <= stat_ok ? S_IDLE : S_POLL;
        end
        S_RESET: if (rst_done) st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // mode and result flags; hardware set wins over software clear
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_r       <= 1'b0;
      err_r        <= 1'b0;
      byp_r        <= 1'b0;
      susp_r       <= 1'b0;
      susp_erase_r <= 1'b0;
      susp_sect_r  <= '0;
    end else begin
      if ((st_r == S_PWAIT && b_ack && stat_ok) ||
          (st_r == S_WAIT && b_ack && s_last && !needs_poll) ||
          (st_r == S_RESET && rst_done))
        done_r <= 1'b1;
      else if (wr_acc && paddr == OFS_STAT && pwdata[ST_DONE])
        done_r <= 1'b0;
      if (take && !legal)
        err_r <= 1'b1;
      else if (wr_acc && paddr == OFS_STAT && pwdata[ST_ERR])
        err_r <= 1'b0;
      if (hw_go_r) begin
        byp_r  <= 1'b0;
        susp_r <= 1'b0;
      end else if (take && legal) begin
        if (cmd_op_r == OP_BYP_ENTER) byp_r <= 1'b1;
        if (cmd_op_r == OP_BYP_EXIT) byp_r <= 1'b0;
        if (cmd_op_r == OP_RESUME) susp_r <= 1'b0;
        if (cmd_op_r == OP_SUSPEND) begin
          susp_r       <= 1'b1;
          susp_erase_r <= (op_r == OP_ERASE);
          susp_sect_r  <= op_addr_r[AW-1:SECT_LSB];
        end
      end
    end
  end

  pfc_bus_cycle u_bus (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .req     (b_req),
    .wr      (b_wr),
    .addr    ((st_r == S_ISSUE) ? s_addr : op_addr_r),
    .wdata   (s_data),
    .ack     (b_ack),
    .rdata   (b_rdata),
    .cs_n    (flash_cs_n),
    .we_n    (flash_we_n),
    .oe_n    (flash_oe_n),
    .f_addr  (flash_addr),
    .dq_o    (flash_dq_o),
    .dq_oe   (flash_dq_oe),
    .dq_i    (flash_dq_i)
  );

  pfc_rst_pulse u_rst (
    .clk_sys     (clk_sys),
    .rst_n       (rst_n),
    .go          (hw_go_r),
    .done        (rst_done),
    .reset_pin_n (flash_reset_n)
  );

  // helper: bus writes issued in the current operation
  logic [2:0] wcnt_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) wcnt_r <= '0;
    else if (take) wcnt_r <= '0;
    else if (b_ack && st_r == S_WAIT && op_r != OP_READ)
      wcnt_r <= wcnt_r + 1'b1;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_prog_four_writes: assert property (
    (st_r == S_PWAIT && first_r && op_r == OP_PROG) |-> wcnt_r == 3'h4)
    else $error("normal program did not use four writes");
  a_bypass_two_writes: assert property (
    (st_r == S_PWAIT && first_r && op_r == OP_BYP_PROG) |-> wcnt_r == 3'h2)
    else $error("bypass program did not use two writes");
  a_seq_then_poll: assert property (
    (st_r == S_WAIT && b_ack && s_last && op_r == OP_ERASE && !hw_go_r)
    |=> st_r == S_POLL ##1 (st_r == S_PWAIT || (st_r == S_ISSUE && susp_r)))
    else $error("erase sequence not followed by polling");
  a_done_needs_ready: assert property (
    (st_r == S_PWAIT && b_ack && !hw_go_r && !ready_busy_n) |=> st_r == S_POLL)
    else $error("finished while device showed busy");
  a_toggle_poll: assert property (
    (st_r == S_PWAIT && b_ack && !hw_go_r && !first_r &&
     b_rdata[DQ_TOG] != tog_r) |=> !done_r || $past(done_r))
    else $error("finished while toggle bit still moving");
  a_susp_read_sect: assert property (
    (st_r == S_ISSUE && op_r == OP_READ && susp_r)
    |-> op_addr_r[AW-1:SECT_LSB] != susp_sect_r)
    else $error("read of suspended sector");
  a_susp_prog_rule: assert property (
    (st_r == S_ISSUE && op_r == OP_PROG && susp_r) |-> susp_erase_r)
    else $error("program issued during program suspend");
  a_reset_pulse: assert property (
    hw_go_r |=> st_r == S_RESET ##1 !flash_reset_n && !byp_r && !susp_r)
    else $error("hardware reset not applied");
  a_apb_wait: assert property (
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one wait state");

  c_bypass_prog: cover property (
    st_r == S_WAIT && b_ack && s_last && op_r == OP_BYP_PROG);
  c_erase_suspend: cover property (take && legal && susp_take);
  c_resume: cover property (take && legal && cmd_op_r == OP_RESUME);
  c_hw_reset: cover property (st_r == S_RESET && rst_done);
endmodule

// file: verif/pfc_flash_model.sv
module pfc_flash_model #(
  parameter int PROG_CYC = 30
) (
  // strobes and pins from the host
  input  wire logic                   clk_sys,
  input  wire logic                   cs_n,
  input  wire logic                   we_n,
  input  wire logic                   oe_n,
  input  wire logic                   reset_n,
  input  wire logic                   wp_n,
  input  wire logic [pfc_pkg::AW-1:0] addr,
  input  wire logic [pfc_pkg::DW-1:0] dq_in,
  // device outputs
  output logic      [pfc_pkg::DW-1:0] dq_out,
  output logic                        ready_busy_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import pfc_pkg::*;
  logic [DW-1:0] mem [logic [AW-2:0]];
  logic [AW-1:0] oa = '0;
  logic [DW-1:0] od = '0, last = '0;
  logic [7:0]    c;
  logic [1:0]    unl = '0;
  logic          byp = 0, pend = 0, ers = 0, xit = 0, tog = 0, eop = 0;
  int            busy = 0;
  wire           lock = !wp_n && oa[AW-1:SECT_LSB] == '0;
  wire           standby = cs_n && reset_n;
  assign ready_busy_n = busy == 0;
  function automatic logic [DW-1:0] word(logic [AW-1:0] a);
    return mem.exists(a[AW-1:1]) ? mem[a[AW-1:1]] : '1;
  endfunction
  // strobe rising edge latches address and data
  always @(posedge we_n) begin
    c = dq_in[7:0];
    if (cs_n || !reset_n || busy != 0) begin
    end else if (pend) begin
      pend = 0;
      oa = addr;
      od = dq_in;
      eop = 0;
      busy = PROG_CYC;
    end else if (byp) begin
      pend = c == CMD_PROG;
      byp = !(xit && c == CMD_BYPX2);
      xit = c == CMD_BYPX1;
    end else if (c == CMD_UNLK1 && addr == ADR_UNLK1) begin
      unl = 1;
    end else if (unl == 1 && c == CMD_UNLK2 && addr == ADR_UNLK2) begin
      unl = 2;
    end else begin
      if (unl == 2 && ers && c == CMD_SECT) begin
        oa = addr;
        od = '1;
        eop = 1;
        busy = 2 * PROG_CYC;
      end
      pend = unl == 2 && c == CMD_PROG;
      byp = unl == 2 && c == CMD_BYPASS;
      ers = unl == 2 && c == CMD_ERASE;
      unl = 0;
    end
  end
  // timer of the embedded operation; reset pin aborts it
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      busy = 0;
      byp = 0;
      pend = 0;
      unl = 0;
    end else if (busy != 0) begin
      busy = busy - 1;
      if (busy == 0 && !lock && !eop)
        mem[oa[AW-1:1]] = word(oa) & od;
      if (busy == 0 && !lock && eop)
        foreach (mem[k])
          if (k[AW-2:SECT_LSB-1] == oa[AW-1:SECT_LSB])
            mem[k] = '1;
    end
  end
  always @(negedge oe_n) if (busy != 0) tog = !tog;
  always @(posedge clk_sys) if (!cs_n && !oe_n) last <= dq_out;
  // released bus shows the inverse, so a stale sample cannot pass
  always @* begin
    dq_out = ~last;
    if (!cs_n && !oe_n && busy != 0) begin
      dq_out = '0;
      dq_out[7] = ~od[7];
      dq_out[DQ_TOG] = tog;
    end else if (!cs_n && !oe_n) dq_out = word(addr);
  end
endmodule

// file: verif/pfc_flash_host_tb.sv
module pfc_flash_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pfc_pkg::*;
  localparam logic [AW-1:0] A0 = 26'h10, A1 = 26'h20010, A2 = 26'h40020;
  localparam logic [DW-1:0] D1 = 64'h0123_4567_89AB_CDEF;
  localparam logic [DW-1:0] D2 = 64'hFF00_FF00_F0F0_0FF0;
  logic          clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]    paddr = '0;
  logic [31:0]   pwdata = '0, prdata, rd, st;
  logic          pready, pslverr, er, cs_n, we_n, oe_n, dq_oe, frst_n;
  logic          wp_n, byte_n, rb_n, saw_rst = 0, saw_busy = 0;
  logic [AW-1:0] fa;
  logic [DW-1:0] dqo, dqm, w;
  wire  [DW-1:0] dqi = dq_oe ? dqo : dqm;
  int            fails = 0, compares = 0, cyc = 0;
  // register rows after reset: offset, data, error
  logic [7:0]    t_a [4] = '{OFS_CFG, OFS_STAT, 8'h24, 8'hFC};
  logic [31:0]   t_d [4] = '{32'h3, 32'h20, 32'h0, 32'h0};
  logic          t_e [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  pfc_flash_host uut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_cs_n(cs_n), .flash_we_n(we_n), .flash_oe_n(oe_n),
    .flash_addr(fa), .flash_dq_o(dqo), .flash_dq_oe(dq_oe),
    .flash_dq_i(dqi), .flash_reset_n(frst_n), .flash_wp_n(wp_n),
    .flash_byte_n(byte_n), .ready_busy_n(rb_n));
  pfc_flash_model #(.PROG_CYC(30)) dev (.clk_sys(clk_sys), .cs_n(cs_n),
    .we_n(we_n), .oe_n(oe_n), .reset_n(frst_n), .wp_n(wp_n), .addr(fa),
    .dq_in(dqi), .dq_out(dqm), .ready_busy_n(rb_n));
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    saw_rst |= !frst_n;
    saw_busy |= !rb_n;
    if (cyc == 90000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // one idle cycle after each transfer keeps psel writes apart
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic op(pfc_op_t o, logic [AW-1:0] a, logic [DW-1:0] d);
    saw_busy = 0;
    apb(1, OFS_ADDR, 32'(a));
    apb(1, OFS_WDLO, d[31:0]);
    apb(1, OFS_WDHI, d[63:32]);
    apb(1, OFS_CTRL, {28'h0, o, 1'b1});
    do apb(0, OFS_STAT, '0); while ((rd[ST_DONE] | rd[ST_ERR]) !== 1'b1);
    st = rd;
    apb(1, OFS_STAT, 32'h6);
  endtask
  task automatic rdw(logic [AW-1:0] a);
    op(OP_READ, a, '0);
    apb(0, OFS_RDLO, '0);
    w[31:0] = rd;
    apb(0, OFS_RDHI, '0);
    w[63:32] = rd;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    foreach (t_a[i]) begin
      apb(0, t_a[i], '0);
      chk("reg data", t_d[i], rd);
      chk("reg error", t_e[i], er);
    end
    $display("register table done");
    op(OP_PROG, A2, D2);
    chk("busy pin", 1'b1, saw_busy);
    op(OP_PROG, A1, D1);
    chk("prog done", 1'b1, st[ST_DONE]);
    rdw(A1);
    chk("prog data", D1, w);
    op(OP_PROG, A1, D2);
    rdw(A1);
    chk("clear only", D1 & D2, w);
    $display("program test done");
    op(OP_ERASE, A1, '0);
    chk("erase busy", 1'b1, saw_busy);
    rdw(A1);
    chk("erased", '1, w);
    rdw(A2);
    chk("other sector", D2, w);
    apb(1, OFS_ADDR, 32'(A1));
    apb(1, OFS_CTRL, {28'h0, OP_ERASE, 1'b1});
    op(OP_SUSPEND, A1, '0);
    chk("suspended", 1'b1, st[ST_SUSP]);
    op(OP_READ, A1, '0);
    chk("suspended sector", 1'b1, st[ST_ERR]);
    op(OP_RESUME, A1, '0);
    chk("resumed", 1'b0, st[ST_SUSP]);
    $display("erase test done");
    op(OP_BYP_PROG, A1, D1);
    chk("bypass refused", 1'b1, st[ST_ERR]);
    op(OP_BYP_ENTER, A1, '0);
    chk("bypass on", 1'b1, st[ST_BYP]);
    op(OP_PROG, A1, D1);
    chk("long refused", 1'b1, st[ST_ERR]);
    op(OP_BYP_PROG, A1, D1);
    rdw(A1);
    chk("bypass data", D1, w);
    op(OP_BYP_EXIT, A1, '0);
    chk("bypass off", 1'b0, st[ST_BYP]);
    op(OP_SUSPEND, A1, '0);
    chk("idle suspend", 1'b1, st[ST_ERR]);
    op(OP_RESUME, A1, '0);
    chk("idle resume", 1'b1, st[ST_ERR]);
    $display("bypass test done");
    op(OP_BYP_ENTER, A1, '0);
    apb(1, OFS_CTRL, 32'h10);
    do apb(0, OFS_STAT, '0); while (rd[ST_DONE] !== 1'b1);
    chk("reset pin", 1'b1, saw_rst);
    chk("reset state", 1'b0, rd[ST_BYP]);
    chk("standby", 1'b1, dev.standby);
    apb(1, OFS_STAT, 32'h6);
    apb(1, OFS_CFG, 32'h2);
    chk("protect pin", 1'b0, wp_n);
    op(OP_PROG, A0, D1);
    rdw(A0);
    chk("protected", '1, w);
    apb(1, OFS_CFG, 32'h1);
    chk("narrow pin", 1'b0, byte_n);
    $display("reset and pin test done");
    summarize();
  end
endmodule
